/* File: logic/ssp_port.sv */
// pipelined synchronous sram bus port: select decode, burst counter,
// byte writes, output turnaround and sleep handling
// assumes the controller drives all synchronous pins from clk_i's domain
//
// Contract
// - select only when all three enables active
// - full write on global or all lanes
// - outputs stay off after write until read
// - data lines off after leaving sleep
// - four-beat burst wraps to start address
`timescale 1ns/1ps
module ssp_port
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // synchronous bus
  input  wire ssp_bus_s          bus_i,
  input  wire logic              sleep_request_i,
  // data pins
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe_o,
  // status
  output logic                   power_ready_o,
  output logic                   asleep_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          slp_sync;
    logic [ADDR_W-1:0]   base;
    logic [BURST_W-1:0]  beat;
    ssp_op_e             op;
    logic                rd_pend;  // read issued, data next cycle
    logic                oe;
    logic [31:0]         pwr_cnt;
    logic                asleep;
  } ssp_state_s;

  ssp_state_s st, next_st;
  logic [DATA_W-1:0] rdata;
  logic [LANES-1:0]  lane_we;
  logic [ADDR_W-1:0] cur_addr;
  logic              sel, strobe, full_wr, any_wr, sleeping;

  function automatic logic selected(input ssp_bus_s b);
    return !b.primary_chip_enable_n && b.depth_enable_high
           && !b.depth_enable_low_n;
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    sleeping = st.slp_sync[1];
    sel      = selected(bus_i);
    strobe   = !bus_i.processor_addr_strobe_n || !bus_i.controller_addr_strobe_n;
    full_wr  = !bus_i.global_write_n ||
               (!bus_i.byte_write_gate_n && bus_i.byte_lane_select_n == '0);
    any_wr   = full_wr || (!bus_i.byte_write_gate_n && bus_i.byte_lane_select_n != '1);
    // processor strobe ignores write controls, so when selected and awake it always starts a read
    if (!bus_i.processor_addr_strobe_n) begin
      any_wr = 1'b0;
    end
    cur_addr = {st.base[ADDR_W-1:BURST_W], st.base[BURST_W-1:0] + st.beat};
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.slp_sync = {st.slp_sync[0], sleep_request_i};
    next_st.asleep   = sleeping;
    next_st.rd_pend  = 1'b0;
    lane_we          = '0;
    if (st.pwr_cnt < POWER_UP_CYC) begin
      next_st.pwr_cnt = st.pwr_cnt + 32'h1;
    end
    if (sleeping) begin
      // outputs off while asleep and on the way out of it
      next_st.oe = 1'b0;
      next_st.op = SSP_IDLE;
    end else if (strobe) begin
      if (sel) begin
        next_st.base = bus_i.addr;
        next_st.beat = BURST_ZERO;
        next_st.op   = any_wr ? SSP_WRITE : SSP_READ;
        if (!any_wr) begin
          next_st.rd_pend = 1'b1;
        end else begin
          lane_we = full_wr ? '1 : ~bus_i.byte_lane_select_n;
          next_st.oe = 1'b0;
        end
      end else begin
        next_st.op = SSP_IDLE;
        next_st.oe = 1'b0;
      end
    end else if (!bus_i.burst_advance_n && st.op != SSP_IDLE) begin
      // two-bit counter rolls back to the start after four beats
      next_st.beat = st.beat + BURST_ONE;
      if (st.op == SSP_READ) begin
        next_st.rd_pend = 1'b1;
      end else if (any_wr) begin
        lane_we = full_wr ? '1 : ~bus_i.byte_lane_select_n;
      end
    end else if (st.op == SSP_READ) begin
      next_st.rd_pend = 1'b1;
    end
    // drive only while read data is in flight: a deselect leaves the last
    // read on the bus one extra cycle, then lets go; sleep always wins
    next_st.oe = st.rd_pend && !sleeping;
    if (next_st.op == SSP_WRITE) begin
      next_st.oe = 1'b0;
    end
  end

  // write uses the strobed address directly, bursts use the counter
  logic [ADDR_W-1:0] mem_addr;
  always_comb begin
    mem_addr = (strobe && sel && !sleeping) ? bus_i.addr :
               {st.base[ADDR_W-1:BURST_W], st.base[BURST_W-1:0] + st.beat + BURST_ONE};
    if (!(strobe && sel) && bus_i.burst_advance_n) begin
      mem_addr = cur_addr;
    end
  end

  ssp_mem #(
    .AW (ADDR_W)
  ) u_mem (
    .clk_i     (clk_i),
    .addr_i    (mem_addr),
    .lane_we_i (lane_we & {LANES{!sleeping}}),
    .wdata_i   (bus_i.wdata),
    .rdata_o   (rdata)
  );

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dq_o <= '0;
    end else if (st.rd_pend) begin
      dq_o <= rdata;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dq_oe_o       = st.oe;
  assign asleep_o      = st.asleep;
  assign power_ready_o = (st.pwr_cnt >= POWER_UP_CYC);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_deselect_write: assert property (@(posedge clk_i) disable iff (reset_i)
    (strobe && !sel) |-> lane_we == '0)
    else $error("write while deselected");

  chk_full_write: assert property (@(posedge clk_i) disable iff (reset_i)
    (strobe && sel && !sleeping && bus_i.processor_addr_strobe_n && !bus_i.global_write_n)
      |-> lane_we == '1)
    else $error("global write missed a lane");

  chk_write_hiz: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.op == SSP_WRITE) |-> !dq_oe_o)
    else $error("outputs on during write");

  chk_sleep_hiz: assert property (@(posedge clk_i) disable iff (reset_i)
    sleeping |=> !dq_oe_o)
    else $error("outputs on in sleep");

  chk_burst_wrap: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.beat == 2'h3 && !strobe && !bus_i.burst_advance_n && st.op != SSP_IDLE
     && !sleeping) |=> st.beat == BURST_ZERO)
    else $error("burst did not wrap");

  chk_burst_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (!strobe && bus_i.burst_advance_n && !sleeping) |=> $stable(st.beat))
    else $error("burst moved without advance");

endmodule

/* File: logic/ssp_pkg.sv */
// shared constants and carrier types for the synchronous sram bus port
// assumes a single 100 MHz clock and a synchronous active-high reset
package ssp_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 10;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int BURST_W = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int POWER_UP_US   = 1000;  // 1 ms before the first access
  localparam int POWER_UP_CYC  = POWER_UP_US * CLK_MHZ;

  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;

  // pins sampled on the rising clock
  typedef struct packed {
    logic                primary_chip_enable_n;
    logic                depth_enable_high;
    logic                depth_enable_low_n;
    logic                processor_addr_strobe_n;
    logic                controller_addr_strobe_n;
    logic                burst_advance_n;
    logic                global_write_n;
    logic                byte_write_gate_n;
    logic [LANES-1:0]    byte_lane_select_n;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } ssp_bus_s;

  typedef enum logic [1:0] {SSP_IDLE, SSP_READ, SSP_WRITE} ssp_op_e;

endpackage

/* File: logic/ssp_mem.sv */
// small synchronous memory with per-lane writes and registered read data
// assumes write and read never hit the same cycle from the port above
`timescale 1ns/1ps
module ssp_mem
  import ssp_pkg::*;
#(
  parameter int AW = ADDR_W
) (
  // clock
  input  wire logic              clk_i,
  // access
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic [LANES-1:0]  lane_we_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);

  logic [DATA_W-1:0] mem [0:(1<<AW)-1];

  // ---------------------------------------------------------------
  // lane writes and registered read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we_i[i]) begin
        mem[addr_i][i*LANE_W +: LANE_W] <= wdata_i[i*LANE_W +: LANE_W];
      end
    end
    rdata_o <= mem[addr_i];
  end

endmodule

/* File: sim/ssp_ctrl.sv */
// memory controller model that drives the port's synchronous pins
// assumes the port samples every pin on the rising edge of clk_i
`timescale 1ns/1ps
module ssp_ctrl
  import ssp_pkg::*;
(
  // clock and status
  input  wire logic clk_i,
  input  wire logic power_ready_i,
  // pins toward the port
  output ssp_bus_s  bus_o,
  output logic      sleep_o
);
  // -------------------------------------------------------------
  // bus cycles
  // -------------------------------------------------------------
  // start deselected with every strobe and write control off
  initial begin
    bus_o   = '1;
    sleep_o = 1'b0;
  end

  // one cycle, k: 0 none, 1 read, 2 global write, 3 lane write, 4 advance,
  // 5 controller strobe only (a deselect when the enables are inactive)
  task automatic cyc(input int k, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [2:0] ce);
    while (power_ready_i !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    #1;
    {bus_o.primary_chip_enable_n, bus_o.depth_enable_high, bus_o.depth_enable_low_n} = ce;
    bus_o.addr = a;
    bus_o.processor_addr_strobe_n = (k != 1);
    bus_o.controller_addr_strobe_n = !(k == 2 || k == 3 || k == 5);
    bus_o.burst_advance_n = (k != 4);
    bus_o.global_write_n = (k != 2);
    bus_o.byte_write_gate_n = (k != 3);
    bus_o.byte_lane_select_n = {LANES{k != 3}};
    // unwritten data toggles so a stale value never looks valid
    bus_o.wdata = (k == 2 || k == 3) ? d : ~bus_o.wdata;
  endtask

  // sleep only changes once a strobed deselect has been sampled
  task automatic nap(input logic on);
    cyc(5, '0, '0, 3'h4);
    cyc(0, '0, '0, 3'h4);
    sleep_o = on;
  endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the synchronous sram bus port
// assumes the ssp_ctrl model drives every input pin of the port except clk_i and reset_i
`timescale 1ns/1ps
module tb_top
  import ssp_pkg::*;
;
  // -------------------------------------------------------------
  // harness
  // -------------------------------------------------------------
  localparam logic [2:0]        SEL = 3'h2;
  localparam logic [ADDR_W-1:0] A   = 10'h100;
  logic              clk_i;
  logic              reset_i;
  ssp_bus_s          bus;
  logic              sleep;
  logic [DATA_W-1:0] dq;
  logic              dq_oe;
  logic              power_ready;
  logic              asleep;
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cycles    = 0;
  int                wait_cyc  = 0;

  ssp_port u_ssp_port (
    .clk_i(clk_i), .reset_i(reset_i), .bus_i(bus), .sleep_request_i(sleep),
    .dq_o(dq), .dq_oe_o(dq_oe), .power_ready_o(power_ready), .asleep_o(asleep)
  );
  ssp_ctrl u_ssp_ctrl (
    .clk_i(clk_i), .power_ready_i(power_ready), .bus_o(bus), .sleep_o(sleep)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // watchdog: power-up wait plus 1000 cycles of traffic
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 101000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic ck(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask

  // distinct lane pattern per address offset
  function automatic logic [DATA_W-1:0] pat(input int o);
    return {LANES{LANE_W'(o * 73 + 11)}};
  endfunction

  task automatic c(input int k, input int o, input logic [2:0] ce = SEL, input logic inv = 1'b0);
    u_ssp_ctrl.cyc(k, A + ADDR_W'(o), inv ? ~pat(o) : pat(o), ce);
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  // read then four advances then holds: wrap to start, then repeat
  task automatic t_burst();
    int exp[7] = '{0, 1, 2, 3, 0, 0, 0};
    for (int i = 0; i < 9; i++) begin
      c(i == 0 ? 1 : (i < 5 ? 4 : 0), 0);
      if (i >= 2) ck(dq_oe === 1'b1 && dq === pat(exp[i-2]), "burst data");
    end
  endtask

  // write right behind a read: bus stays off until the next read
  task automatic t_turn();
    int k[8] = '{1, 2, 0, 0, 0, 1, 0, 0};
    for (int i = 0; i < 8; i++) begin
      c(k[i], i == 0 ? 0 : 4);
      if (i >= 2 && i < 7) ck(dq_oe === 1'b0, "bus off after write");
    end
    c(0, 4);
    ck(dq_oe === 1'b1 && dq === pat(4), "read after write");
  endtask

  // each enable alone at its inactive level blocks writes and reads
  task automatic t_desel();
    logic [2:0] bad[3] = '{3'h6, 3'h0, 3'h3};
    foreach (bad[j]) begin
      c(2, 0, bad[j], 1'b1);
      for (int i = 0; i < 4; i++) c(1, 0, bad[j]);
      ck(dq_oe === 1'b0, "deselected read");
    end
    c(1, 0);
    repeat (3) c(0, 0);
    ck(dq === pat(0), "deselected write ignored");
  endtask

  // a read issued while asleep must not turn the bus on after waking
  task automatic t_sleep();
    u_ssp_ctrl.nap(1'b1);
    for (int i = 0; i < 8 && asleep !== 1'b1; i++) c(0, 0, 3'h4);
    ck(asleep === 1'b1, "sleep entered");
    c(1, 0);
    u_ssp_ctrl.nap(1'b0);
    for (int i = 0; i < 8 && asleep !== 1'b0; i++) c(0, 0, 3'h4);
    repeat (3) c(0, 0, 3'h4);
    ck(asleep === 1'b0 && dq_oe === 1'b0, "bus off after sleep");
  endtask

  initial begin
    reset_i = 1'b1;
    repeat (10) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    ck(power_ready === 1'b0 && dq_oe === 1'b0, "reset state");
    // count edges until the port reports that the power-up wait is over
    while (power_ready !== 1'b1) begin
      @(posedge clk_i);
      #1;
      wait_cyc++;
    end
    ck(wait_cyc == POWER_UP_CYC, "power-up wait length");
    c(2, 0);
    c(2, 1);
    c(3, 2);
    c(3, 3);
    t_burst();
    t_turn();
    t_desel();
    t_sleep();
    complete_run();
  end
endmodule
